// [timer16_core_byte_access_tb.sv]
// Self-checking bench for the 16-bit timer core behind its APB byte bus.
// Assumes the CPU model makes every bus transfer; capture and count pins driven here.
`timescale 1ns/100ps
`default_nettype none
module timer16_core_byte_access_tb;
   typedef struct packed {
      logic [7:0]  lo;
      logic [15:0] v;
   } tmr_row_t;
   logic        pclk;
   logic        presetn;
   logic        compat_mode;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        bottom;
   logic        at_max;
   logic        irq_request;
   logic        cap_pin;
   logic        ext_pin;
   logic        wave_a;
   logic        wave_b;
   logic [7:0]  q;
   logic        e;
   logic [15:0] v;
   logic [15:0] v2;
   int          err_count = 0;
   int          checks_done = 0;
   tmr_row_t    rows [3] = '{'{tmr_pkg::OFS_CMPA_LO, 16'ha55a},
      '{tmr_pkg::OFS_CMPB_LO, 16'h1234}, '{tmr_pkg::OFS_CNT_LO, 16'h01ff}};

   // Second instance, so legacy mode can switch it off
   tmr_core #(.SECOND_INSTANCE(1'b1)) i_tmr_core (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .compat_mode(compat_mode),
      .external_count_pin(ext_pin), .capture_pin(cap_pin), .comparator_out(1'b0),
      .wave_out_a(wave_a), .wave_out_b(wave_b), .bottom(bottom), .at_max(at_max),
      .irq_request(irq_request));
   tmr_cpu_model i_tmr_cpu_model (
      .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic final_report();
      err_count += i_tmr_cpu_model.timeouts;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      if (i_tmr_cpu_model.timeouts > 0) final_report();
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic w(input logic [7:0] a, input logic [7:0] d);
      i_tmr_cpu_model.xfer(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a);
      i_tmr_cpu_model.xfer(1'b0, a, 8'h00, q, e);
   endtask

   initial begin
      presetn = 1'b0;
      compat_mode = 1'b0;
      cap_pin = 1'b0;
      ext_pin = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      chk(16'({bottom, at_max, irq_request}), 16'h0004);
      foreach (rows[i]) begin
         i_tmr_cpu_model.wr16(rows[i].lo, rows[i].v);
         i_tmr_cpu_model.rd16(rows[i].lo, v);
         chk(v, rows[i].v);
      end
      $display("wide table done");
      w(tmr_pkg::OFS_CNT_HI, 8'h77);
      i_tmr_cpu_model.rd16(tmr_pkg::OFS_CNT_LO, v);
      chk(v, 16'h01ff);
      rd(tmr_pkg::OFS_CNT_LO);
      rd(tmr_pkg::OFS_CMPA_HI);
      chk(16'(q), 16'h00a5);
      rd(tmr_pkg::OFS_CNT_HI);
      chk(16'(q), 16'h0001);
      i_tmr_cpu_model.wr16(tmr_pkg::OFS_CAP_LO, 16'hbeef);
      i_tmr_cpu_model.rd16(tmr_pkg::OFS_CAP_LO, v);
      chk(v, 16'h0000);
      w(tmr_pkg::OFS_CTRL_A, 8'h02);
      w(tmr_pkg::OFS_CTRL_B, 8'h18);
      rd(tmr_pkg::OFS_CTRL_B);
      chk(16'(q), 16'h0018);
      i_tmr_cpu_model.wr16(tmr_pkg::OFS_CAP_LO, 16'hbeef);
      i_tmr_cpu_model.rd16(tmr_pkg::OFS_CAP_LO, v);
      chk(v, 16'hbeef);
      w(tmr_pkg::OFS_CTRL_A, 8'h00);
      w(tmr_pkg::OFS_CTRL_B, 8'h00);
      $display("holding and capture done");
      i_tmr_cpu_model.wr16(tmr_pkg::OFS_CNT_LO, 16'hffff);
      repeat (5) @(posedge pclk);
      #1;
      chk(16'({bottom, at_max}), 16'h0001);
      i_tmr_cpu_model.wr16(tmr_pkg::OFS_CNT_LO, 16'h0000);
      #1;
      chk(16'({bottom, at_max}), 16'h0002);
      w(tmr_pkg::OFS_FLAG, 8'h0f);
      rd(tmr_pkg::OFS_FLAG);
      chk(16'(q), 16'h0000);
      i_tmr_cpu_model.wr16(tmr_pkg::OFS_CNT_LO, 16'h1234);
      rd(tmr_pkg::OFS_FLAG);
      chk(16'(q), 16'h0004);
      chk(16'(irq_request), 16'h0000);
      w(tmr_pkg::OFS_MASK, 8'h04);
      #1;
      chk(16'(irq_request), 16'h0001);
      w(tmr_pkg::OFS_CTRL_A, 8'h0c);
      #1;
      chk(16'({wave_a, wave_b}), 16'h0003);
      rd(tmr_pkg::OFS_CTRL_A);
      chk(16'(q), 16'h0000);
      $display("limits and flags done");
      w(tmr_pkg::OFS_CTRL_B, 8'h01);
      w(tmr_pkg::OFS_CTRL_B, 8'h00);
      i_tmr_cpu_model.rd16(tmr_pkg::OFS_CNT_LO, v);
      repeat (4) @(posedge pclk);
      i_tmr_cpu_model.rd16(tmr_pkg::OFS_CNT_LO, v2);
      chk(v, 16'h1237);
      chk(v2, v);
      // Two rising edges on the count pin give two ticks
      w(tmr_pkg::OFS_CTRL_B, 8'h07);
      repeat (2) begin
         ext_pin <= 1'b1;
         repeat (2) @(posedge pclk);
         ext_pin <= 1'b0;
         repeat (2) @(posedge pclk);
      end
      w(tmr_pkg::OFS_CTRL_B, 8'h00);
      i_tmr_cpu_model.rd16(tmr_pkg::OFS_CNT_LO, v);
      chk(v, 16'h1239);
      w(tmr_pkg::OFS_CTRL_B, 8'h40);
      cap_pin <= 1'b1;
      repeat (3) @(posedge pclk);
      i_tmr_cpu_model.rd16(tmr_pkg::OFS_CAP_LO, v);
      chk(v, 16'h1239);
      rd(tmr_pkg::OFS_FLAG);
      chk(16'(q[tmr_pkg::FL_CAPTURE]), 16'h0001);
      w(tmr_pkg::OFS_CTRL_B, 8'h18);
      compat_mode <= 1'b1;
      rd(tmr_pkg::OFS_CTRL_B);
      chk(16'({e, q}), 16'h0100);
      w(tmr_pkg::OFS_CTRL_B, 8'h00);
      compat_mode <= 1'b0;
      rd(tmr_pkg::OFS_CTRL_B);
      chk(16'(q), 16'h0018);
      rd(8'h3c);
      chk(16'(e), 16'h0001);
      $display("clock and legacy done");
      final_report();
   end
endmodule
`default_nettype wire

// [tmr_cap_edge.sv]
// Capture trigger: source select, optional 4-sample noise filter, edge detect.
// Assumes capture inputs are synchronous to pclk.
`timescale 1ns/100ps
`default_nettype none
module tmr_cap_edge (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic capture_pin,
   input  wire logic comparator_out,
   input  wire logic use_comparator,
   input  wire logic filter_en,
   input  wire logic rising,
   output logic      capture_event
);
   logic [3:0] hist_ff;
   logic       level_ff;
   logic       prev_ff;
   logic       src;

   assign src = use_comparator ? comparator_out : capture_pin;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hist_ff <= '0;
      end else begin
         hist_ff <= {hist_ff[2:0], src};
      end
   end

   // Filter trades four cycles of delay for spike rejection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_ff <= 1'b0;
      end else if (!filter_en) begin
         level_ff <= src;
      end else if (&hist_ff || ~|hist_ff) begin
         level_ff <= hist_ff[0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_ff <= 1'b0;
      end else begin
         prev_ff <= level_ff;
      end
   end

   assign capture_event = rising ? (level_ff & ~prev_ff) : (~level_ff & prev_ff);
endmodule
`default_nettype wire

// [tmr_clk_sel.sv]
// Timer tick generator: free running prescaler plus external pin edge detect.
// Assumes the external count pin is synchronous to pclk.
`timescale 1ns/100ps
`default_nettype none
module tmr_clk_sel (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [2:0] clock_select_field,
   input  wire logic       external_count_pin,
   output logic            timer_tick
);
   logic [9:0] presc_ff;
   logic       pin_ff;
   logic       nxt_tick;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_ff <= '0;
      end else begin
         presc_ff <= presc_ff + 10'h001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_ff <= 1'b0;
      end else begin
         pin_ff <= external_count_pin;
      end
   end

   // Source and active edge both chosen here
   always_comb begin
      unique case (tmr_pkg::tmr_clksel_t'(clock_select_field))
         tmr_pkg::CS_STOP:     nxt_tick = 1'b0;
         tmr_pkg::CS_DIV1:     nxt_tick = 1'b1;
         tmr_pkg::CS_DIV8:     nxt_tick = (presc_ff & tmr_pkg::DIV8_MASK) == '0;
         tmr_pkg::CS_DIV64:    nxt_tick = (presc_ff & tmr_pkg::DIV64_MASK) == '0;
         tmr_pkg::CS_DIV256:   nxt_tick = (presc_ff & tmr_pkg::DIV256_MASK) == '0;
         tmr_pkg::CS_DIV1K:    nxt_tick = (presc_ff & tmr_pkg::DIV1K_MASK) == '0;
         tmr_pkg::CS_EXT_FALL: nxt_tick = pin_ff & ~external_count_pin;
         tmr_pkg::CS_EXT_RISE: nxt_tick = ~pin_ff & external_count_pin;
      endcase
   end

   assign timer_tick = nxt_tick;
endmodule
`default_nettype wire

// [tmr_core.sv]
// 16-bit timer/counter core with byte-wide wide-register access over APB.
// Assumes one APB master on pclk; second instance disabled by compat_mode.
// Notes on behaviour
// - Counter, compares and capture are 16 bits, reached as two byte accesses.
// - One shared 8-bit high-byte holding register per timer.
// - Low-byte write loads holding byte plus new low byte in one cycle.
// - Counter or capture low-byte read copies that register's upper byte into the holding register.
// - Compare register reads bypass the holding register entirely.
// - Bottom is signalled whenever the counter is zero.
// - Max is signalled whenever the counter is all ones.
// - Top is a fixed value, compare A, or capture, chosen by mode.
// - Compare A as top holds output A low in PWM modes, where top reads the CPU-side buffer directly.
// - Both buffered compares match continuously and set their flags.
// - Qualifying capture edge stores counter; optional noise filter.
// - Clock source and active edge are selectable.
// - With no clock source the counter neither counts nor clears.
// - Control registers are plain byte registers, no holding register.
// - Every request shows in the flag register; its mask gates it into the interrupt request.
// - Control A takes force bits but does not store them; control B holds the third and fourth mode bits.
// - In compatibility mode only the first instance is available.
// - A CPU counter write beats any clear or count in that cycle.
// - Capture flag sets in the same cycle as the capture load.
// - Capture accepts writes only in modes using it as top.
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module tmr_core #(
   parameter bit SECOND_INSTANCE = 1'b0
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        compat_mode,
   input  wire logic        external_count_pin,
   input  wire logic        capture_pin,
   input  wire logic        comparator_out,
   output logic             wave_out_a,
   output logic             wave_out_b,
   output logic             bottom,
   output logic             at_max,
   output logic             irq_request
);
   tmr_pkg::tmr_apb_req_t req;
   logic [7:0]  control_a_ff;
   logic [7:0]  control_b_ff;
   logic [7:0]  hold_ff;
   logic [15:0] count_value_ff;
   logic [15:0] compare_a_value_ff;
   logic [15:0] compare_b_value_ff;
   logic [15:0] cmpa_buf_ff;
   logic [15:0] cmpb_buf_ff;
   logic [15:0] capture_value_ff;
   logic [tmr_pkg::NUM_FLAGS-1:0] flag_ff;
   logic [tmr_pkg::NUM_FLAGS-1:0] mask_ff;
   logic [tmr_pkg::NUM_FLAGS-1:0] set_ev;
   logic        wave_a_ff;
   logic        wave_b_ff;
   logic [31:0] prdata_ff;
   logic [3:0]  wave_mode;
   logic [15:0] top_value;
   logic        cap_is_top;
   logic        cmpa_is_top;
   logic        pwm_mode;
   logic        timer_tick;
   logic        capture_event;
   logic        avail;
   logic        wr_acc;
   logic        rd_acc;
   logic        addr_ok;
   logic [31:0] nxt_rdata;
   logic        at_top;

   assign req = '{sel: psel, en: penable, wr: pwrite, addr: paddr, wdata: pwdata};
   assign avail = !(SECOND_INSTANCE && compat_mode);
   assign wr_acc = req.sel && req.en && req.wr && avail;
   assign rd_acc = req.sel && req.en && !req.wr && avail;
   assign wave_mode = {control_b_ff[tmr_pkg::CB_WAVE3], control_b_ff[tmr_pkg::CB_WAVE2],
                       control_a_ff[tmr_pkg::CA_WAVE1], control_a_ff[tmr_pkg::CA_WAVE0]};

   // Top select; unlisted codes count to max
   always_comb begin
      top_value   = tmr_pkg::CNT_MAX;
      cap_is_top  = 1'b0;
      cmpa_is_top = 1'b0;
      pwm_mode    = 1'b1;
      case (wave_mode)
         4'h1, 4'h5: top_value = tmr_pkg::TOP_8BIT;
         4'h2, 4'h6: top_value = tmr_pkg::TOP_9BIT;
         4'h3, 4'h7: top_value = tmr_pkg::TOP_10BIT;
         4'h4: begin
            top_value   = compare_a_value_ff;
            cmpa_is_top = 1'b1;
            pwm_mode    = 1'b0;
         end
         4'hc: begin
            top_value  = capture_value_ff;
            cap_is_top = 1'b1;
            pwm_mode   = 1'b0;
         end
         4'h8, 4'ha, 4'he: begin
            top_value  = capture_value_ff;
            cap_is_top = 1'b1;
         end
         4'h9, 4'hb, 4'hf: begin
            top_value   = cmpa_buf_ff;
            cmpa_is_top = 1'b1;
         end
         default: pwm_mode = 1'b0;
      endcase
   end

   tmr_clk_sel u_clk (
      .pclk               (pclk),
      .presetn            (presetn),
      .clock_select_field (control_b_ff[2:0]),
      .external_count_pin (external_count_pin),
      .timer_tick         (timer_tick)
   );

   tmr_cap_edge u_cap (
      .pclk           (pclk),
      .presetn        (presetn),
      .capture_pin    (capture_pin),
      .comparator_out (comparator_out),
      .use_comparator (control_b_ff[tmr_pkg::CB_CAP_SRC] && !SECOND_INSTANCE),
      .filter_en      (control_b_ff[7]),
      .rising         (control_b_ff[tmr_pkg::CB_CAP_EDGE]),
      .capture_event  (capture_event)
   );

   assign at_top = count_value_ff == top_value;

   // Shared holding register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_ff <= '0;
      end else if (wr_acc && (req.addr == tmr_pkg::OFS_CNT_HI || req.addr == tmr_pkg::OFS_CMPA_HI
                  || req.addr == tmr_pkg::OFS_CMPB_HI || req.addr == tmr_pkg::OFS_CAP_HI)) begin
         hold_ff <= req.wdata[7:0];
      end else if (rd_acc && req.addr == tmr_pkg::OFS_CNT_LO) begin
         hold_ff <= count_value_ff[15:8];
      end else if (rd_acc && req.addr == tmr_pkg::OFS_CAP_LO) begin
         hold_ff <= capture_value_ff[15:8];
      end
   end

   // Counter: CPU write first, then count; idle with no tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_value_ff <= '0;
      end else if (wr_acc && req.addr == tmr_pkg::OFS_CNT_LO) begin
         count_value_ff <= {hold_ff, req.wdata[7:0]};
      end else if (timer_tick) begin
         count_value_ff <= at_top ? tmr_pkg::CNT_BOTTOM : count_value_ff + 16'h0001;
      end
   end

   // Compare registers: CPU side buffer, active copy at top in PWM modes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmpa_buf_ff <= '0;
         cmpb_buf_ff <= '0;
      end else if (wr_acc && req.addr == tmr_pkg::OFS_CMPA_LO) begin
         cmpa_buf_ff <= {hold_ff, req.wdata[7:0]};
      end else if (wr_acc && req.addr == tmr_pkg::OFS_CMPB_LO) begin
         cmpb_buf_ff <= {hold_ff, req.wdata[7:0]};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare_a_value_ff <= '0;
         compare_b_value_ff <= '0;
      end else if (!pwm_mode || (timer_tick && at_top)) begin
         compare_a_value_ff <= cmpa_buf_ff;
         compare_b_value_ff <= cmpb_buf_ff;
      end
   end

   // Capture register: write only when it defines top
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capture_value_ff <= '0;
      end else if (wr_acc && req.addr == tmr_pkg::OFS_CAP_LO && cap_is_top) begin
         capture_value_ff <= {hold_ff, req.wdata[7:0]};
      end else if (capture_event && !cap_is_top) begin
         capture_value_ff <= count_value_ff;
      end
   end

   // Control registers, plain byte access; force bits read back zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_a_ff <= '0;
         control_b_ff <= '0;
         mask_ff      <= '0;
      end else if (wr_acc) begin
         if (req.addr == tmr_pkg::OFS_CTRL_A) begin
            control_a_ff <= req.wdata[7:0] & 8'hf3;
         end
         if (req.addr == tmr_pkg::OFS_CTRL_B) begin
            control_b_ff <= req.wdata[7:0];
         end
         if (req.addr == tmr_pkg::OFS_MASK) begin
            mask_ff <= req.wdata[tmr_pkg::NUM_FLAGS-1:0];
         end
      end
   end

   wire force_a = wr_acc && req.addr == tmr_pkg::OFS_CTRL_A && req.wdata[tmr_pkg::CA_FORCE_A];
   wire force_b = wr_acc && req.addr == tmr_pkg::OFS_CTRL_A && req.wdata[tmr_pkg::CA_FORCE_B];

   // Match and event sources
   always_comb begin
      set_ev = '0;
      set_ev[tmr_pkg::FL_OVF]     = timer_tick && (pwm_mode ? at_top
                                    : count_value_ff == tmr_pkg::CNT_MAX);
      set_ev[tmr_pkg::FL_MATCH_A] = count_value_ff == compare_a_value_ff;
      set_ev[tmr_pkg::FL_MATCH_B] = count_value_ff == compare_b_value_ff;
      set_ev[tmr_pkg::FL_CAPTURE] = capture_event && !cap_is_top;
   end

   // Sticky flags, write one to clear, set wins over clear
   genvar gi;
   generate
      for (gi = 0; gi < tmr_pkg::NUM_FLAGS; gi++) begin : g_flag
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               flag_ff[gi] <= 1'b0;
            end else if (set_ev[gi]) begin
               flag_ff[gi] <= 1'b1;
            end else if (wr_acc && req.addr == tmr_pkg::OFS_FLAG && req.wdata[gi]) begin
               flag_ff[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   assign irq_request = |(flag_ff & mask_ff);

   // Waveform: toggle on match or force; A silent when it sets top in PWM modes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wave_a_ff <= 1'b0;
         wave_b_ff <= 1'b0;
      end else begin
         if (cmpa_is_top && pwm_mode) begin
            wave_a_ff <= 1'b0;
         end else if ((timer_tick && set_ev[tmr_pkg::FL_MATCH_A]) || force_a) begin
            wave_a_ff <= ~wave_a_ff;
         end
         if ((timer_tick && set_ev[tmr_pkg::FL_MATCH_B]) || force_b) begin
            wave_b_ff <= ~wave_b_ff;
         end
      end
   end

   assign wave_out_a = wave_a_ff;
   assign wave_out_b = wave_b_ff;
   assign bottom = count_value_ff == tmr_pkg::CNT_BOTTOM;
   assign at_max = count_value_ff == tmr_pkg::CNT_MAX;

   // Read mux; compare bytes direct, high bytes of others from holding
   always_comb begin
      addr_ok   = 1'b1;
      nxt_rdata = tmr_pkg::RESET_WORD;
      unique case (req.addr)
         tmr_pkg::OFS_CTRL_A:  nxt_rdata[7:0] = control_a_ff;
         tmr_pkg::OFS_CTRL_B:  nxt_rdata[7:0] = control_b_ff;
         tmr_pkg::OFS_CNT_LO:  nxt_rdata[7:0] = count_value_ff[7:0];
         tmr_pkg::OFS_CNT_HI:  nxt_rdata[7:0] = hold_ff;
         tmr_pkg::OFS_CMPA_LO: nxt_rdata[7:0] = cmpa_buf_ff[7:0];
         tmr_pkg::OFS_CMPA_HI: nxt_rdata[7:0] = cmpa_buf_ff[15:8];
         tmr_pkg::OFS_CMPB_LO: nxt_rdata[7:0] = cmpb_buf_ff[7:0];
         tmr_pkg::OFS_CMPB_HI: nxt_rdata[7:0] = cmpb_buf_ff[15:8];
         tmr_pkg::OFS_CAP_LO:  nxt_rdata[7:0] = capture_value_ff[7:0];
         tmr_pkg::OFS_CAP_HI:  nxt_rdata[7:0] = hold_ff;
         tmr_pkg::OFS_FLAG:    nxt_rdata[tmr_pkg::NUM_FLAGS-1:0] = flag_ff;
         tmr_pkg::OFS_MASK:    nxt_rdata[tmr_pkg::NUM_FLAGS-1:0] = mask_ff;
         tmr_pkg::OFS_STATUS:  nxt_rdata[1:0] = {at_max, bottom};
         default:              addr_ok = 1'b0;
      endcase
   end

   // Read data registered in the setup cycle so it is stable in access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= tmr_pkg::RESET_WORD;
      end else if (req.sel && !req.en && !req.wr) begin
         prdata_ff <= avail ? nxt_rdata : tmr_pkg::RESET_WORD;
      end
   end

   assign prdata  = prdata_ff;
   assign pready  = 1'b1;
   assign pslverr = req.sel && req.en && (!addr_ok || !avail);

   // Holding register picks up counter high byte on low read
   a_hold_on_read: assert property (@(posedge pclk) disable iff (!presetn)
      rd_acc && req.addr == tmr_pkg::OFS_CNT_LO |=> hold_ff == $past(count_value_ff[15:8]))
      else $error("holding byte not loaded on low read");
   a_low_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_acc && req.addr == tmr_pkg::OFS_CNT_LO
      |=> count_value_ff == {$past(hold_ff), $past(req.wdata[7:0])})
      else $error("counter not loaded from holding plus low byte");
   a_high_only: assert property (@(posedge pclk) disable iff (!presetn)
      wr_acc && req.addr == tmr_pkg::OFS_CMPB_HI |=> $stable(cmpb_buf_ff))
      else $error("high byte write changed a wide register");
   a_idle_stop: assert property (@(posedge pclk) disable iff (!presetn)
      control_b_ff[2:0] == 3'b000 && !wr_acc ##1 control_b_ff[2:0] == 3'b000
      |-> $stable(count_value_ff))
      else $error("counter moved with no clock source");
   a_cap_flag: assert property (@(posedge pclk) disable iff (!presetn)
      capture_event && !cap_is_top |=> flag_ff[tmr_pkg::FL_CAPTURE]
      && capture_value_ff == $past(count_value_ff))
      else $error("capture flag and load not together");
   a_cap_locked: assert property (@(posedge pclk) disable iff (!presetn)
      wr_acc && req.addr == tmr_pkg::OFS_CAP_LO && !cap_is_top && !capture_event
      |=> $stable(capture_value_ff))
      else $error("capture written outside top mode");
   a_match_flag: assert property (@(posedge pclk) disable iff (!presetn)
      count_value_ff == compare_b_value_ff |=> flag_ff[tmr_pkg::FL_MATCH_B])
      else $error("match b flag not set");
   a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
      mask_ff == '0 |-> !irq_request)
      else $error("masked request raised interrupt");
   a_compat_off: assert property (@(posedge pclk) disable iff (!presetn)
      !avail && req.sel |=> $stable(control_b_ff))
      else $error("unavailable instance accepted write");
endmodule
`default_nettype wire

// [tmr_cpu_model.sv]
// APB master standing in for the CPU on the timer's byte bus.
// Assumes the bench calls one task at a time.
`timescale 1ns/100ps
`default_nettype none
module tmr_cpu_model (
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   int timeouts = 0;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // Each transfer ends before the next, so two transfers never use the holding byte at once
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (n >= 40) timeouts++;
      q = prdata[7:0];
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // High byte first on writes, low byte first on reads
   task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
      logic [7:0] q;
      logic       e;
      xfer(1'b1, lo + 8'h04, v[15:8], q, e);
      xfer(1'b1, lo, v[7:0], q, e);
   endtask
   task automatic rd16(input logic [7:0] lo, output logic [15:0] v);
      logic e;
      xfer(1'b0, lo, 8'h00, v[7:0], e);
      xfer(1'b0, lo + 8'h04, 8'h00, v[15:8], e);
   endtask
endmodule
`default_nettype wire

// [tmr_pkg.sv]
// Package for the 16-bit timer core: register map, field layout, modes.
// Assumes an APB slave with 32-bit data, one byte-wide register per word.
package tmr_pkg;
   localparam logic [7:0] OFS_CTRL_A   = 8'h00;
   localparam logic [7:0] OFS_CTRL_B   = 8'h04;
   localparam logic [7:0] OFS_CNT_LO   = 8'h08;
   localparam logic [7:0] OFS_CNT_HI   = 8'h0c;
   localparam logic [7:0] OFS_CMPA_LO  = 8'h10;
   localparam logic [7:0] OFS_CMPA_HI  = 8'h14;
   localparam logic [7:0] OFS_CMPB_LO  = 8'h18;
   localparam logic [7:0] OFS_CMPB_HI  = 8'h1c;
   localparam logic [7:0] OFS_CAP_LO   = 8'h20;
   localparam logic [7:0] OFS_CAP_HI   = 8'h24;
   localparam logic [7:0] OFS_FLAG     = 8'h28;
   localparam logic [7:0] OFS_MASK     = 8'h2c;
   localparam logic [7:0] OFS_STATUS   = 8'h30;

   // control_a bits
   localparam int CA_FORCE_A  = 3;
   localparam int CA_FORCE_B  = 2;
   localparam int CA_WAVE1    = 1;
   localparam int CA_WAVE0    = 0;
   // control_b bits
   localparam int CB_CAP_EDGE = 6;
   localparam int CB_WAVE3    = 4;
   localparam int CB_WAVE2    = 3;
   localparam int CB_CAP_SRC  = 5;
   // flag and mask bit positions
   localparam int FL_OVF      = 0;
   localparam int FL_MATCH_A  = 1;
   localparam int FL_MATCH_B  = 2;
   localparam int FL_CAPTURE  = 3;
   localparam int NUM_FLAGS   = 4;

   localparam logic [15:0] CNT_BOTTOM = 16'h0000;
   localparam logic [15:0] CNT_MAX    = 16'hffff;
   localparam logic [15:0] TOP_8BIT   = 16'h00ff;
   localparam logic [15:0] TOP_9BIT   = 16'h01ff;
   localparam logic [15:0] TOP_10BIT  = 16'h03ff;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;

   typedef enum logic [2:0] {
      CS_STOP   = 3'b000,
      CS_DIV1   = 3'b001,
      CS_DIV8   = 3'b010,
      CS_DIV64  = 3'b011,
      CS_DIV256 = 3'b100,
      CS_DIV1K  = 3'b101,
      CS_EXT_FALL = 3'b110,
      CS_EXT_RISE = 3'b111
   } tmr_clksel_t;

   // Prescaler taps
   localparam logic [9:0] DIV8_MASK   = 10'h007;
   localparam logic [9:0] DIV64_MASK  = 10'h03f;
   localparam logic [9:0] DIV256_MASK = 10'h0ff;
   localparam logic [9:0] DIV1K_MASK  = 10'h3ff;

   typedef struct packed {
      logic        sel;
      logic        en;
      logic        wr;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } tmr_apb_req_t;
endpackage
